// File: src/rxtm_pkg.sv
// Package of constants and types for the receive slot map block
package rxtm_pkg;
	// Register word addresses on the host port (word addressed, 12 bits)
	localparam logic [11:0] RXTM_ADDR_MASK_LO   = 12'h710;  // Slot mask 15:0, one per link
	localparam logic [11:0] RXTM_ADDR_MASK_HI   = 12'h720;  // Slot mask 31:16, one per link
	localparam logic [11:0] RXTM_ADDR_SYNC_FLT  = 12'h730;  // Sticky sync fault flags
	localparam logic [11:0] RXTM_ADDR_AUTO_SYNC = 12'h741;  // Auto sync constant
	localparam logic [11:0] RXTM_ADDR_LINK_CTL  = 12'h742;  // Link enables / delineation mode
	localparam logic [11:0] RXTM_ADDR_XFER_CMD  = 12'h743;  // Transfer command / busy
	localparam logic [11:0] RXTM_ADDR_INT_STAT  = 12'h744;  // Interrupt status, read only
	localparam logic [11:0] RXTM_ADDR_INT_CLR   = 12'h745;  // Interrupt clear, write only
	localparam logic [11:0] RXTM_ADDR_INT_EN    = 12'h746;  // Interrupt enable
	localparam logic [11:0] RXTM_ADDR_BUF_BASE  = 12'h800;  // Control cell buffer base
	localparam logic [1:0]  RXTM_BUF_TOP2       = 2'b10;    // addr[11:10] of buffer region
	// Layout
	localparam int          RXTM_LINKS          = 16;       // Receive links
	localparam int          RXTM_SLOTS          = 32;       // Slots per frame
	localparam int          RXTM_BUF_WORDS      = 1024;     // 32 blocks of 32 words
	localparam logic [9:0]  RXTM_OLD_STRIDE     = 10'h040;  // Old cell block per link
	localparam logic [9:0]  RXTM_NEW_OFFSET     = 10'h020;  // New cell above old
	localparam logic [15:0] RXTM_MASK_RST       = 16'h0000; // Mask reset value
	localparam logic [15:0] RXTM_FLT_RST        = 16'h0000; // Fault flags reset value
	localparam logic [7:0]  RXTM_AUTO_RST       = 8'h00;    // Auto sync reset value
	localparam logic [7:0]  RXTM_AUTO_BITMODE   = 8'h36;    // Value software loads in bit mode
	localparam int          RXTM_LINK_CTL_MODE  = 0;        // Bit: 1 = bit-mode delineation
	localparam int          RXTM_LINK_CTL_AUTO  = 1;        // Bit: auto cell sync on lane link
	// Interrupt status bits
	localparam int          RXTM_IRQ_SYNC_FLT   = 0;        // A sync fault was raised
	localparam int          RXTM_IRQ_XFER_DONE  = 1;        // Transfer to internal memory done
	localparam int          RXTM_IRQ_BITS       = 2;
	// Sync fault detection: frame length in link bits, checked per frame
	localparam int          RXTM_FRAME_BITS     = 256;      // 32 slots x 8 bits
	// Copy engine: cycles busy after a command, 1024 words plus the done cycle
	localparam logic [10:0] RXTM_XFER_CYCLES    = 11'h401;
	// Transfer engine states
	typedef enum logic [1:0] {
		RXTM_XF_IDLE = 2'b00,  // Waiting for command
		RXTM_XF_COPY = 2'b01,  // Copying words
		RXTM_XF_DONE = 2'b10   // Signalling completion
	} rxtm_xf_state_t;
endpackage : rxtm_pkg

// File: src/rxtm_link_rx.sv
// One receive link: link clock edge finder, slot counter, sync check, bit gatherer
`timescale 1ns/10ps
module rxtm_link_rx import rxtm_pkg::*; (
	input  wire logic        clk,          // System clock
	input  wire logic        rstn,         // Synchronous reset, active low
	input  wire logic        link_clk_in,  // Link clock pin
	input  wire logic        rx_frame_sync_in, // Frame sync pin
	input  wire logic        rx_serial_data_in, // Serial data pin
	input  wire logic [31:0] slot_mask,    // Slot enables, bit n = slot n
	output logic             bit_valid,    // Pulse: one cell bit gathered
	output logic             bit_data,     // Gathered bit
	output logic             sync_fault    // Pulse: sync arrived off frame boundary
);
	logic [1:0] clk_sync_q;  // Link clock synchroniser
	logic [1:0] fs_sync_q;   // Frame sync synchroniser
	logic [1:0] dat_sync_q;  // Data synchroniser
	logic       clk_prev_q;  // Last synchronised clock level
	logic [7:0] bit_cnt_q;   // Bit position in frame
	logic       framed_q;    // Seen at least one sync
	logic       rise;        // Link clock rising edge

	// Two-flop synchronisers on every pin
	always_ff @(posedge clk) begin
		if (!rstn) begin
			clk_sync_q <= 2'b00;
			fs_sync_q  <= 2'b00;
			dat_sync_q <= 2'b00;
			clk_prev_q <= 1'b0;
		end else begin
			clk_sync_q <= {clk_sync_q[0], link_clk_in};
			fs_sync_q  <= {fs_sync_q[0], rx_frame_sync_in};
			dat_sync_q <= {dat_sync_q[0], rx_serial_data_in};
			clk_prev_q <= clk_sync_q[1];
		end
	end

	assign rise = clk_sync_q[1] && !clk_prev_q;

	// Bit counter; sync restarts it, a sync off the boundary is a fault
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bit_cnt_q  <= 8'h00;
			framed_q   <= 1'b0;
			sync_fault <= 1'b0;
		end else begin
			sync_fault <= 1'b0;
			if (rise) begin
				if (fs_sync_q[1]) begin
					// A sync anywhere but bit 0 of an expected frame is faulty
					sync_fault <= framed_q && (bit_cnt_q != 8'h00);
					bit_cnt_q  <= 8'h01;
					framed_q   <= 1'b1;
				end else begin
					bit_cnt_q <= bit_cnt_q + 8'h01; // Wraps at 256 bits
				end
			end
		end
	end

	// Gather only bits of enabled slots; masked slots ignore the pin
	always_ff @(posedge clk) begin
		if (!rstn) begin
			bit_valid <= 1'b0;
			bit_data  <= 1'b0;
		end else begin
			bit_valid <= 1'b0;
			if (rise && (framed_q || fs_sync_q[1])) begin
				bit_valid <= fs_sync_q[1] ? slot_mask[0] : slot_mask[bit_cnt_q[7:3]];
				bit_data  <= dat_sync_q[1];
			end
		end
	end
endmodule : rxtm_link_rx

// File: src/rxtm_cell_buf.sv
// Control cell buffer with host port and copy into internal memory
`timescale 1ns/10ps
module rxtm_cell_buf import rxtm_pkg::*; (
	input  wire logic        clk,       // System clock
	input  wire logic        rstn,      // Synchronous reset, active low
	input  wire logic        wr_en,     // Host write to buffer
	input  wire logic        rd_en,     // Host read of buffer
	input  wire logic [9:0]  addr,      // Word index in buffer
	input  wire logic [15:0] wdata,     // Host write data
	output logic [15:0]      rdata,     // Read data, one cycle later
	input  wire logic        xfer_go,   // Pulse: start copy
	output logic             xfer_busy, // Copy in progress
	output logic             xfer_done  // Pulse: copy finished
);
	logic [15:0] buf_mem [RXTM_BUF_WORDS];  // Host-visible buffer, content unknown at power-up
	logic [15:0] int_mem [RXTM_BUF_WORDS];  // Internal copy used by the cell logic
	logic [9:0]  xf_idx_q;                  // Copy pointer
	rxtm_xf_state_t xf_state_q;             // Copy state

	// Host access; no reset so this maps onto RAM
	always_ff @(posedge clk) begin
		if (wr_en)
			buf_mem[addr] <= wdata;
		rdata <= rd_en ? buf_mem[addr] : 16'h0000;
	end

	// Copy engine, one word per cycle
	always_ff @(posedge clk) begin
		if (!rstn) begin
			xf_state_q <= RXTM_XF_IDLE;
			xf_idx_q   <= 10'h000;
			xfer_done  <= 1'b0;
		end else begin
			xfer_done <= 1'b0;
			case (xf_state_q)
				RXTM_XF_IDLE: begin
					xf_idx_q <= 10'h000;
					if (xfer_go)
						xf_state_q <= RXTM_XF_COPY;
				end
				RXTM_XF_COPY: begin
					xf_idx_q <= xf_idx_q + 10'h001;
					if (xf_idx_q == 10'h3ff)
						xf_state_q <= RXTM_XF_DONE;
				end
				RXTM_XF_DONE: begin
					xfer_done  <= 1'b1;
					xf_state_q <= RXTM_XF_IDLE;
				end
				default: xf_state_q <= RXTM_XF_IDLE;
			endcase
		end
	end

	// Internal memory write side
	always_ff @(posedge clk) begin
		if (xf_state_q == RXTM_XF_COPY)
			int_mem[xf_idx_q] <= buf_mem[xf_idx_q];
	end

	assign xfer_busy = (xf_state_q != RXTM_XF_IDLE);
endmodule : rxtm_cell_buf

// File: src/rxtm_top.sv
// Receive slot map registers, sync fault flags, auto sync constant and cell buffer
`timescale 1ns/10ps
// Summary of operation
// - Sixteen low slot masks, slots 0-15
// - Sixteen high slot masks, slots 16-31
// - Masked slots: serial data ignored
// - All masks reset to zero
// - Shared sticky sync fault flags, bit per link
// - Writing zero clears a fault flag
// - Auto constant ignored in byte mode
// - Init auto constant before auto sync
// - Buffer: 32 blocks of 32 words
// - Old cell at 0x40*link, new +0x20
// - Transfer command copies buffer inward
module rxtm_top import rxtm_pkg::*; (
	input  wire logic        clk,               // System clock, 50 MHz
	input  wire logic        rstn,              // Synchronous reset, active low
	input  wire logic [11:0] addr,              // Register word address
	input  wire logic [15:0] wdata,             // Write data
	input  wire logic        wr,                // Write strobe
	input  wire logic        rd,                // Read strobe
	output logic [15:0]      rdata,             // Read data, cycle after rd
	input  wire logic [15:0] link_clk_in,       // Per-link receive clocks
	input  wire logic [15:0] rx_frame_sync_in,  // Per-link frame sync
	input  wire logic [15:0] rx_serial_data_in, // Per-link serial data
	output logic [15:0]      cell_bit_valid,    // Per-link gathered bit strobe
	output logic [15:0]      cell_bit_data,     // Per-link gathered bit
	output logic [7:0]       auto_sync_value,   // Constant used by bit-mode delineation
	output logic             irq                // Level interrupt
);
	logic [15:0] mask_lo_q [RXTM_LINKS];  // Low slot masks
	logic [15:0] mask_hi_q [RXTM_LINKS];  // High slot masks
	logic [15:0] flt_q;                   // Sticky sync fault flags
	logic [7:0]  auto_q;                  // Auto sync constant
	logic [15:0] auto_en_q;               // Per-link auto cell sync enable
	logic        bit_mode_q;              // Bit-mode delineation
	logic [RXTM_IRQ_BITS-1:0] ist_q;      // Interrupt status
	logic [RXTM_IRQ_BITS-1:0] ien_q;      // Interrupt enable
	logic [15:0] lnk_valid;               // From link receivers
	logic [15:0] lnk_data;                // Gathered bit per link
	logic [15:0] lnk_fault;               // Sync fault pulses
	logic [15:0] buf_rdata;               // Buffer read data
	logic        buf_sel_q;               // Last read was buffer
	logic [15:0] reg_rdata_q;             // Register read data
	logic        xfer_go;                 // Transfer command pulse
	logic        xfer_busy;               // Copy engine running
	logic        xfer_done;               // Copy engine finished, one cycle
	logic        buf_hit;                 // Address lies in the buffer window
	logic        wr_flt;                  // Write to the fault flags
	logic        wr_ctl;                  // Write to link control
	logic [10:0] xf_len_q;                // Helper: busy cycles of the copy

	// Decode a per-link register window of sixteen words
	// Only the upper eight address bits are compared; the low nibble
	// then picks the link, so both mask banks share one decoder
	function automatic logic in_bank(input logic [11:0] a, input logic [11:0] base);
		in_bank = (a[11:4] == base[11:4]);
	endfunction

	// Buffer window: the two top address bits alone select it
	assign buf_hit = (addr[11:10] == RXTM_BUF_TOP2);
	// Write to the shared fault flag word
	assign wr_flt  = wr && (addr == RXTM_ADDR_SYNC_FLT);
	// Write to link control
	assign wr_ctl  = wr && (addr == RXTM_ADDR_LINK_CTL);
	// A command while busy is dropped; restarting a running copy would
	// leave internal memory half old and half new
	assign xfer_go = wr && (addr == RXTM_ADDR_XFER_CMD) && wdata[0] && !xfer_busy;

	// Slot mask registers, one pair per link
	genvar g;
	generate
		for (g = 0; g < RXTM_LINKS; g++) begin : g_link
			always_ff @(posedge clk) begin
				if (!rstn) begin
					mask_lo_q[g] <= RXTM_MASK_RST;
					mask_hi_q[g] <= RXTM_MASK_RST;
				end else if (wr) begin
					if (addr == RXTM_ADDR_MASK_LO + 12'(g))
						mask_lo_q[g] <= wdata;
					if (addr == RXTM_ADDR_MASK_HI + 12'(g))
						mask_hi_q[g] <= wdata;
				end
			end

			// Link receiver; high mask bit 8 is slot 24, unused on T1
			rxtm_link_rx u_link (
				.clk               (clk),
				.rstn              (rstn),
				.link_clk_in       (link_clk_in[g]),
				.rx_frame_sync_in  (rx_frame_sync_in[g]),
				.rx_serial_data_in (rx_serial_data_in[g]),
				.slot_mask         ({mask_hi_q[g], mask_lo_q[g]}),
				.bit_valid         (lnk_valid[g]),
				.bit_data          (lnk_data[g]),
				.sync_fault        (lnk_fault[g])
			);
		end
	endgenerate

	// Sticky fault flags; a new fault beats a clear in the same cycle
	// so that a fault arriving while software clears is never lost
	always_ff @(posedge clk) begin
		if (!rstn)
			flt_q <= RXTM_FLT_RST;                // All links clean
		else if (wr_flt)
			// Zero clears, one keeps the flag as it is
			flt_q <= (flt_q & wdata) | lnk_fault;
		else
			// Only new faults change the word
			flt_q <= flt_q | lnk_fault;
	end

	// Auto sync constant and link control
	always_ff @(posedge clk) begin
		if (!rstn) begin
			auto_q     <= RXTM_AUTO_RST;
			auto_en_q  <= 16'h0000;
			bit_mode_q <= 1'b0;
		end else begin
			// Upper byte of the write is dropped; it always reads zero
			if (wr && addr == RXTM_ADDR_AUTO_SYNC)
				auto_q <= wdata[7:0];
			// One link's auto enable per write; the others are cleared,
			// a limitation software must keep in mind
			if (wr_ctl) begin
				bit_mode_q <= wdata[RXTM_LINK_CTL_MODE];
				auto_en_q  <= {15'h0000, wdata[RXTM_LINK_CTL_AUTO]} << wdata[7:4];
			end
		end
	end

	// Constant reaches delineation only in bit mode
	always_ff @(posedge clk) begin
		if (!rstn)
			auto_sync_value <= 8'h00;
		else
			auto_sync_value <= (bit_mode_q && |auto_en_q) ? auto_q : 8'h00;
	end

	// Registered cell bit outputs
	// One cycle of latency is traded for outputs straight from flops
	always_ff @(posedge clk) begin
		if (!rstn) begin
			cell_bit_valid <= 16'h0000;
			cell_bit_data  <= 16'h0000;
		end else begin
			cell_bit_valid <= lnk_valid;
			cell_bit_data  <= lnk_data;
		end
	end

	// Interrupt status: sticky, set beats clear
	// The line is computed from the next status value so that it
	// drops in the same cycle as the status bit it stands for
	always_ff @(posedge clk) begin
		logic [RXTM_IRQ_BITS-1:0] set_v;
		logic [RXTM_IRQ_BITS-1:0] clr_v;
		set_v = '0;
		set_v[RXTM_IRQ_SYNC_FLT]  = |lnk_fault;
		set_v[RXTM_IRQ_XFER_DONE] = xfer_done;
		clr_v = (wr && addr == RXTM_ADDR_INT_CLR) ? wdata[RXTM_IRQ_BITS-1:0] : '0;
		if (!rstn) begin
			ist_q <= '0;
			ien_q <= '0;
			irq   <= 1'b0;
		end else begin
			ist_q <= (ist_q & ~clr_v) | set_v;
			if (wr && addr == RXTM_ADDR_INT_EN)
				ien_q <= wdata[RXTM_IRQ_BITS-1:0];
			irq <= |(((ist_q & ~clr_v) | set_v) & ien_q);
		end
	end

	// Buffer; old block at link*0x40, new 0x20 above, host-addressed directly
	rxtm_cell_buf u_buf (
		.clk       (clk),
		.rstn      (rstn),
		.wr_en     (wr && buf_hit),
		.rd_en     (rd && buf_hit),
		.addr      (addr[9:0]),
		.wdata     (wdata),
		.rdata     (buf_rdata),
		.xfer_go   (xfer_go),
		.xfer_busy (xfer_busy),
		.xfer_done (xfer_done)
	);

	// Register read path, answered the cycle after rd
	// Read data is zero outside the answer cycle, so a stale word
	// is never mistaken for a fresh one
	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata_q <= 16'h0000;
			buf_sel_q   <= 1'b0;
		end else begin
			// Remember which source answers next cycle
			buf_sel_q   <= rd && buf_hit;
			reg_rdata_q <= 16'h0000;
			if (rd) begin
				// Mask banks first, then the single registers
				if (in_bank(addr, RXTM_ADDR_MASK_LO))
					reg_rdata_q <= mask_lo_q[addr[3:0]];
				else if (in_bank(addr, RXTM_ADDR_MASK_HI))
					reg_rdata_q <= mask_hi_q[addr[3:0]];
				else
					case (addr)
						RXTM_ADDR_SYNC_FLT:  reg_rdata_q <= flt_q;
						RXTM_ADDR_AUTO_SYNC: reg_rdata_q <= {8'h00, auto_q}; // Upper byte zero
						RXTM_ADDR_LINK_CTL:  reg_rdata_q <= {15'h0000, bit_mode_q};
						RXTM_ADDR_XFER_CMD:  reg_rdata_q <= {15'h0000, xfer_busy};
						RXTM_ADDR_INT_STAT:  reg_rdata_q <= {14'h0000, ist_q};
						RXTM_ADDR_INT_EN:    reg_rdata_q <= {14'h0000, ien_q};
						default:             reg_rdata_q <= 16'h0000;
					endcase
			end
		end
	end

	assign rdata = buf_sel_q ? buf_rdata : reg_rdata_q;

	// Helper for the copy length check: counts cycles with the engine busy.
	// A delay of over a thousand cycles is too costly to unroll, so the
	// span is counted here and judged when busy drops.
	always_ff @(posedge clk) begin
		if (!rstn)
			xf_len_q <= 11'h000;
		else if (xfer_busy)
			xf_len_q <= xf_len_q + 11'h001; // One more busy cycle
		else
			xf_len_q <= 11'h000;            // Idle: start over
	end

	// Checks
	a_mask_reset: assert property (@(posedge clk) !rstn |=> mask_lo_q[0] == 16'h0000)
		else $error("mask not reset");
	a_flt_reset: assert property (@(posedge clk) !rstn |=> flt_q == 16'h0000)
		else $error("fault flags not reset");
	a_mask_write: assert property (@(posedge clk) disable iff (!rstn)
		wr && addr == RXTM_ADDR_MASK_HI |=> mask_hi_q[0] == $past(wdata))
		else $error("high mask write lost");
	a_mask_lo_write: assert property (@(posedge clk) disable iff (!rstn)
		wr && addr == RXTM_ADDR_MASK_LO |=> mask_lo_q[0] == $past(wdata))
		else $error("low mask write lost");
	a_flt_sticky: assert property (@(posedge clk) disable iff (!rstn)
		flt_q[0] && !(wr_flt && !wdata[0]) |=> flt_q[0])
		else $error("fault flag dropped");
	a_flt_set: assert property (@(posedge clk) disable iff (!rstn)
		lnk_fault[3] |=> flt_q[3])
		else $error("fault not captured");
	a_flt_clear: assert property (@(posedge clk) disable iff (!rstn)
		wr_flt && !wdata[5] && !lnk_fault[5] |=> !flt_q[5])
		else $error("fault not cleared");
	a_auto_byte: assert property (@(posedge clk) disable iff (!rstn)
		!bit_mode_q |=> auto_sync_value == 8'h00)
		else $error("auto constant leaked in byte mode");
	a_auto_read: assert property (@(posedge clk) disable iff (!rstn)
		rd && addr == RXTM_ADDR_AUTO_SYNC |=> rdata[15:8] == 8'h00)
		else $error("auto upper byte nonzero");
	a_xfer_start: assert property (@(posedge clk) disable iff (!rstn)
		xfer_go |=> xfer_busy)
		else $error("transfer did not start");
	a_xfer_len: assert property (@(posedge clk) disable iff (!rstn)
		$fell(xfer_busy) |-> xf_len_q == RXTM_XFER_CYCLES)
		else $error("transfer length wrong");
	a_xfer_bound: assert property (@(posedge clk) disable iff (!rstn)
		xf_len_q <= RXTM_XFER_CYCLES)
		else $error("transfer ran too long");
	a_masked_slot: assert property (@(posedge clk) disable iff (!rstn)
		mask_lo_q[0] == 16'h0000 && mask_hi_q[0] == 16'h0000 |=> !lnk_valid[0])
		else $error("masked slot gathered");
	c_fault_seen: cover property (@(posedge clk) disable iff (!rstn) |lnk_fault);
	c_xfer_done:  cover property (@(posedge clk) disable iff (!rstn) xfer_done);
	c_bit_taken:  cover property (@(posedge clk) disable iff (!rstn) |cell_bit_valid);
	c_flt_clear:  cover property (@(posedge clk) disable iff (!rstn) wr_flt && flt_q[0] && !wdata[0]);
	c_bit_mode:   cover property (@(posedge clk) disable iff (!rstn) auto_sync_value != 8'h00);
endmodule : rxtm_top

// File: tb/rxtm_framer_model.sv
// Behavioural model of one external framer driving a receive link
`timescale 1ns/10ps
module rxtm_framer_model;
	logic link_clk_in;        // Link clock, still between frames
	logic rx_frame_sync_in;   // Frame sync, active high
	logic rx_serial_data_in;  // Serial data
	// Idle lines at start
	initial begin
		link_clk_in = 1'b0;
		rx_frame_sync_in = 1'b0;
		rx_serial_data_in = 1'b0;
	end
	// One 256-bit frame; 160 ns bit period, data set up 40 ns before the rise
	task automatic frame(input logic [255:0] pat, input int sync_bit);
		for (int i = 0; i < 256; i++) begin
			rx_serial_data_in = pat[i];
			rx_frame_sync_in = (i == sync_bit);
			#40 link_clk_in = 1'b1;
			#80 link_clk_in = 1'b0;
			#40;
		end
		// Released line: inverse of last bit so no stale value looks valid
		rx_serial_data_in = ~pat[255];
		rx_frame_sync_in = 1'b0;
	endtask
endmodule // rxtm_framer_model

// File: tb/test_rxtm_top.sv
// Self-checking bench for the receive slot map register block
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
	$display("BAD at %0t: got %h want %h", $time, (a), (e)); end end
module test_rxtm_top;
	import rxtm_pkg::*;
	logic        clk, rstn, wr, rd;     // Clock, reset, strobes
	logic [11:0] addr;                  // Word address
	logic [15:0] wdata, rdata;          // Host data
	logic [15:0] link_clk_in, rx_frame_sync_in, rx_serial_data_in; // Link pins
	logic [15:0] cell_bit_valid, cell_bit_data; // Gathered bits
	logic [7:0]  auto_sync_value;       // Delineation constant
	logic        irq;                   // Interrupt line
	int          mismatches, num_checks, other_strobes;
	logic        got[$];                // Bits gathered on link 0
	logic [15:0] v;
	rxtm_top u_rxtm_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata), .link_clk_in(link_clk_in),
		.rx_frame_sync_in(rx_frame_sync_in), .rx_serial_data_in(rx_serial_data_in),
		.cell_bit_valid(cell_bit_valid), .cell_bit_data(cell_bit_data),
		.auto_sync_value(auto_sync_value), .irq(irq));
	// One framer per link; only link 0 carries frames
	for (genvar i = 0; i < 16; i++) begin : g_link
		rxtm_framer_model u_rxtm_framer_model ();
		assign link_clk_in[i] = u_rxtm_framer_model.link_clk_in;
		assign rx_frame_sync_in[i] = u_rxtm_framer_model.rx_frame_sync_in;
		assign rx_serial_data_in[i] = u_rxtm_framer_model.rx_serial_data_in;
	end
	initial clk = 1'b0;
	always #10 clk = ~clk;
	// Collect link 0 bits; any strobe elsewhere is wrong
	always @(posedge clk) begin
		if (cell_bit_valid[0] === 1'b1) got.push_back(cell_bit_data[0]);
		if (cell_bit_valid[15:1] !== 15'h0000) other_strobes++;
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Bus write: one strobe cycle, then one idle cycle
	task automatic wr_reg(input logic [11:0] a, input logic [15:0] d);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		@(posedge clk);
	endtask
	// Bus read: data sampled in the cycle after the strobe only
	task automatic rd_reg(input logic [11:0] a, output logic [15:0] d);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
		@(posedge clk);
	endtask
	// Interrupt line: looked at just after the edge, then one edge passes
	task automatic irq_chk(input logic e);
		#1 `CHK(irq, e)
		@(posedge clk);
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [15:0] e);
		logic [15:0] d;
		rd_reg(a, d);
		`CHK(d, e)
	endtask
	// Reset values of every mask, the fault flags, the auto constant and the interrupt line
	task automatic t_reset_values();
		for (int i = 0; i < 16; i++) begin
			rd_chk(RXTM_ADDR_MASK_LO + 12'(i), RXTM_MASK_RST);
			rd_chk(RXTM_ADDR_MASK_HI + 12'(i), RXTM_MASK_RST);
		end
		rd_chk(RXTM_ADDR_SYNC_FLT, 16'h0000);
		rd_chk(RXTM_ADDR_AUTO_SYNC, 16'h0000);
		`CHK(irq, 1'b0)
		$display("test reset values done");
	endtask
	// Distinct mask per link, read back; T1-style high masks keep bit 8 clear
	task automatic t_masks();
		for (int i = 0; i < 16; i++) begin
			wr_reg(RXTM_ADDR_MASK_LO + 12'(i), 16'ha5c0 ^ 16'(i));
			wr_reg(RXTM_ADDR_MASK_HI + 12'(i), 16'h5e00 ^ 16'(i));
		end
		for (int i = 0; i < 16; i++) begin
			rd_chk(RXTM_ADDR_MASK_LO + 12'(i), 16'ha5c0 ^ 16'(i));
			rd_chk(RXTM_ADDR_MASK_HI + 12'(i), 16'h5e00 ^ 16'(i));
		end
		rd_chk(12'h7ff, 16'h0000);
		$display("test masks done");
	endtask
	// Buffer words at old and new cell blocks of first and last link
	task automatic t_buffer();
		for (int l = 0; l < 16; l += 15) begin
			wr_reg(RXTM_ADDR_BUF_BASE + 12'(l * 'h40), 16'h1100 + 16'(l));
			wr_reg(RXTM_ADDR_BUF_BASE + 12'(l * 'h40 + 'h3f), 16'h2200 + 16'(l));
		end
		for (int l = 0; l < 16; l += 15) begin
			rd_chk(RXTM_ADDR_BUF_BASE + 12'(l * 'h40), 16'h1100 + 16'(l));
			rd_chk(RXTM_ADDR_BUF_BASE + 12'(l * 'h40 + 'h3f), 16'h2200 + 16'(l));
		end
		$display("test buffer done");
	endtask
	// Transfer command, completion interrupt raised, masked, cleared
	task automatic t_transfer();
		wr_reg(RXTM_ADDR_XFER_CMD, 16'h0001);
		rd_chk(RXTM_ADDR_XFER_CMD, 16'h0001);
		repeat (1030) @(posedge clk);
		rd_chk(RXTM_ADDR_XFER_CMD, 16'h0000);
		rd_chk(RXTM_ADDR_INT_STAT, 16'h0002);
		`CHK(irq, 1'b0)
		wr_reg(RXTM_ADDR_INT_EN, 16'h0002);
		irq_chk(1'b1);
		wr_reg(RXTM_ADDR_INT_CLR, 16'h0002);
		rd_chk(RXTM_ADDR_INT_STAT, 16'h0000);
		`CHK(irq, 1'b0)
		$display("test transfer done");
	endtask
	// Only slots 0 and 31 of link 0 gathered; then a misplaced sync
	task automatic t_link();
		logic [255:0] pat;
		pat = {32'hc3a5_0f69, 192'h0, 32'h9e17_4b2d};
		wr_reg(RXTM_ADDR_MASK_LO, 16'h0001);
		wr_reg(RXTM_ADDR_MASK_HI, 16'h8000);
		for (int i = 1; i < 16; i++) wr_reg(RXTM_ADDR_MASK_LO + 12'(i), 16'h0000);
		wr_reg(RXTM_ADDR_INT_EN, 16'h0001);
		got.delete();
		other_strobes = 0;
		g_link[0].u_rxtm_framer_model.frame(pat, 0);
		repeat (10) @(posedge clk);
		`CHK(got.size(), 16)
		for (int i = 0; i < 16 && i < got.size(); i++)
			`CHK(got[i], pat[i < 8 ? i : 240 + i])
		`CHK(other_strobes, 0)
		rd_chk(RXTM_ADDR_SYNC_FLT, 16'h0000);
		g_link[0].u_rxtm_framer_model.frame(pat, 5);
		repeat (10) @(posedge clk);
		rd_chk(RXTM_ADDR_SYNC_FLT, 16'h0001);
		`CHK(irq, 1'b1)
		wr_reg(RXTM_ADDR_SYNC_FLT, 16'hffff);
		rd_chk(RXTM_ADDR_SYNC_FLT, 16'h0001);
		wr_reg(RXTM_ADDR_SYNC_FLT, 16'hfffe);
		rd_chk(RXTM_ADDR_SYNC_FLT, 16'h0000);
		wr_reg(RXTM_ADDR_INT_CLR, 16'h0001);
		`CHK(irq, 1'b0)
		$display("test link done");
	endtask
	// Constant loaded first; used in bit mode only
	task automatic t_auto_sync();
		wr_reg(RXTM_ADDR_AUTO_SYNC, 16'hff36);
		rd_chk(RXTM_ADDR_AUTO_SYNC, 16'h0036);
		wr_reg(RXTM_ADDR_LINK_CTL, 16'h0002);
		repeat (3) @(posedge clk);
		`CHK(auto_sync_value, 8'h00)
		wr_reg(RXTM_ADDR_LINK_CTL, 16'h0003);
		repeat (3) @(posedge clk);
		`CHK(auto_sync_value, RXTM_AUTO_BITMODE)
		$display("test auto sync done");
	endtask
	// Main sequence
	initial begin
		mismatches = 0;
		num_checks = 0;
		other_strobes = 0;
		rstn = 1'b0;
		wr = 1'b0;
		rd = 1'b0;
		addr = 12'h000;
		wdata = 16'h0000;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_reset_values();
		t_masks();
		t_buffer();
		t_transfer();
		t_link();
		t_auto_sync();
		finish_test();
	end
	// Watchdog well beyond the expected run of about 109 us
	initial begin
		#1_000_000;
		mismatches++;
		finish_test();
	end
endmodule // test_rxtm_top
